// *** rfsc_pkg.sv ***
// constants for the receiver filter and sync configuration bank
package rfsc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CODE_W = 4;
   localparam int SLEN_W = 2;
   localparam int NREG   = 3;

   // register offsets, reset values and writable-bit masks
   localparam logic [ADDR_W-1:0] FILT_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] POLY_OFS = 8'h11;
   localparam logic [ADDR_W-1:0] SYNC_OFS = 8'h12;
   localparam logic [DATA_W-1:0] FILT_RST = 8'hA3;
   localparam logic [DATA_W-1:0] POLY_RST = 8'h38;
   localparam logic [DATA_W-1:0] SYNC_RST = 8'h18;
   localparam logic [DATA_W-1:0] FILT_WMASK = 8'hFF;
   localparam logic [DATA_W-1:0] POLY_WMASK = 8'hF0;
   localparam logic [DATA_W-1:0] SYNC_WMASK = 8'hFE;
   localparam int FILT_IDX = 0;
   localparam int POLY_IDX = 1;
   localparam int SYNC_IDX = 2;
   localparam logic [ADDR_W-1:0] REG_OFS   [0:NREG-1] = '{FILT_OFS, POLY_OFS, SYNC_OFS};
   localparam logic [DATA_W-1:0] REG_RST   [0:NREG-1] = '{FILT_RST, POLY_RST, SYNC_RST};
   localparam logic [DATA_W-1:0] REG_WMASK [0:NREG-1] = '{FILT_WMASK, POLY_WMASK, SYNC_WMASK};

   // field positions
   localparam int PASS_HI = 7;
   localparam int PASS_LO = 4;
   localparam int BUTT_HI = 3;
   localparam int BUTT_LO = 0;
   localparam int POLY_HI = 7;
   localparam int POLY_LO = 4;
   localparam int PRSV_HI = 3;
   localparam int PRSV_LO = 0;
   localparam logic [CODE_W-1:0] PRSV_VAL = 4'h8;
   localparam int POLY_ON_BIT = 7;
   localparam int BSYNC_BIT   = 6;
   localparam int SREC_BIT    = 5;
   localparam int SLEN_HI     = 4;
   localparam int SLEN_LO     = 3;
   localparam int STOL_HI     = 2;
   localparam int STOL_LO     = 1;
   localparam int SRSV_BIT    = 0;

   // frequency and length scaling
   localparam int PASS_KHZ_W   = 10;
   localparam int FREQ_W       = 12;
   localparam int SBITS_W      = 6;
   localparam int BASE_KHZ     = 200;
   localparam int STEP_DIV     = 8;
   localparam int XTAL_REF_KHZ = 12800;
   localparam int SYNC_STEP    = 8;
   localparam logic [PASS_KHZ_W-1:0] PASS_KHZ [0:15] = '{
      10'h041, 10'h052, 10'h06D, 10'h089, 10'h09D, 10'h0B8, 10'h0D3, 10'h0EA,
      10'h106, 10'h141, 10'h17A, 10'h19E, 10'h1CA, 10'h202, 10'h2A4, 10'h3DB};
   localparam logic [PASS_KHZ_W-1:0] PASS_KHZ_RST = 10'h17A;
   localparam logic [FREQ_W-1:0]     FREQ_RST     = 12'h064;
   localparam logic [SBITS_W-1:0]    SBITS_RST    = 6'h20;
endpackage

// *** rfsc_code_if.sv ***
// code fields handed from the register bank to the code translator
interface rfsc_code_if import rfsc_pkg::*; ;
   logic [CODE_W-1:0] pass_code;
   logic [CODE_W-1:0] butt_code;
   logic [CODE_W-1:0] poly_code;
   logic [SLEN_W-1:0] slen_code;
   modport regs (output pass_code, butt_code, poly_code, slen_code);
   modport calc (input  pass_code, butt_code, poly_code, slen_code);
endinterface

// *** rfsc_code_calc.sv ***
// translates configuration codes into nominal bandwidths and sync length
module rfsc_code_calc import rfsc_pkg::*; #(
   parameter int XTAL_KHZ = XTAL_REF_KHZ
) (
   // clock, reset, enable
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   // codes from the bank
   rfsc_code_if.calc                  codes,
   // translated values
   output logic      [PASS_KHZ_W-1:0] pass_khz,
   output logic      [FREQ_W-1:0]     butt_ofs_khz,
   output logic      [FREQ_W-1:0]     poly_khz,
   output logic      [SBITS_W-1:0]    sync_bits
);
   logic [PASS_KHZ_W-1:0] pass_khz_nxt;
   logic [FREQ_W-1:0]     butt_ofs_nxt;
   logic [FREQ_W-1:0]     poly_khz_nxt;
   logic [SBITS_W-1:0]    sync_bits_nxt;

   // scaled by the crystal ratio; integer kHz, truncated
   function automatic logic [FREQ_W-1:0] freq_khz(input logic [CODE_W-1:0] code);
      logic [31:0] prod;
      prod = 32'(BASE_KHZ) * 32'(XTAL_KHZ) * (32'(code) + 32'h1);
      return FREQ_W'(prod / (32'(XTAL_REF_KHZ) * 32'(STEP_DIV)));
   endfunction

   always_comb begin
      pass_khz_nxt  = PASS_KHZ[codes.pass_code];
      butt_ofs_nxt  = freq_khz(codes.butt_code);
      poly_khz_nxt  = freq_khz(codes.poly_code);
      sync_bits_nxt = SBITS_W'((32'(codes.slen_code) + 32'h1) * 32'(SYNC_STEP));
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pass_khz     <= PASS_KHZ_RST;
         butt_ofs_khz <= FREQ_RST;
         poly_khz     <= FREQ_RST;
         sync_bits    <= SBITS_RST;
      end else if (ce) begin
         pass_khz     <= pass_khz_nxt;
         butt_ofs_khz <= butt_ofs_nxt;
         poly_khz     <= poly_khz_nxt;
         sync_bits    <= sync_bits_nxt;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   pass_table_a: assert property (ce |=> pass_khz == PASS_KHZ[$past(codes.pass_code)])
      else $error("passive filter bandwidth does not follow its code");
   pass_ends_a: assert property (ce && codes.pass_code == 4'hF |=> pass_khz == 10'h3DB)
      else $error("top passive code does not give the widest bandwidth");
   butt_freq_a: assert property (ce |=> butt_ofs_khz == freq_khz($past(codes.butt_code)))
      else $error("butterworth offset does not follow its code");
   poly_freq_a: assert property (ce && codes.poly_code == 4'h3 |=> poly_khz == FREQ_RST)
      else $error("polyphase code three does not give the recommended centre");
   sync_len_a: assert property (ce |=>
      sync_bits == ($past(codes.slen_code) + 6'h1) * 6'h8)
      else $error("sync length does not follow its code");
endmodule

// *** rfsc_cfg_bank.sv ***
// receiver filter and sync configuration register bank
// How it works
// - filter register upper nibble is the passive low-pass bandwidth code, reset 1010
// - passive code maps monotonically to 65..987 kHz over sixteen steps
// - filter register lower nibble is the butterworth code, reset 0011
// - butterworth offset is 200 kHz times crystal ratio times (1+code)/8
// - polyphase upper nibble sets centre frequency likewise, reset 0011 giving 100 kHz
// - sync bit six set disables the bit synchronizer in continuous receive
// - two-bit sync length code selects 8, 16, 24 or 32 bits, reset 32
// - two-bit tolerance code equals accepted sync bit mismatches, zero to three
//
// Implementation choice: the plain strobed port.
module rfsc_cfg_bank import rfsc_pkg::*; #(
   parameter int XTAL_KHZ = XTAL_REF_KHZ
) (
   // clock, reset, enable
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   // register port
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_W-1:0]     reg_rdata,
   // receive mode from the radio sequencer
   input  wire logic                  continuous_rx_mode,
   input  wire logic                  ook_rx_mode,
   // configuration fields
   output logic      [CODE_W-1:0]     passive_lpf_code,
   output logic      [CODE_W-1:0]     butterworth_cutoff_code,
   output logic      [CODE_W-1:0]     polyphase_centre_code,
   output logic                       polyphase_filter_on,
   output logic                       bit_sync_disable,
   output logic                       sync_word_recognition_on,
   output logic      [SLEN_W-1:0]     sync_word_length,
   output logic      [SLEN_W-1:0]     sync_error_tolerance,
   // qualified enables
   output logic                       polyphase_filter_active,
   output logic                       bit_sync_active,
   // translated values
   output logic      [PASS_KHZ_W-1:0] passive_lpf_khz,
   output logic      [FREQ_W-1:0]     butterworth_offset_khz,
   output logic      [FREQ_W-1:0]     polyphase_centre_khz,
   output logic      [SBITS_W-1:0]    sync_word_bits
);
   logic [DATA_W-1:0] regs_r   [0:NREG-1];
   logic [DATA_W-1:0] regs_nxt [0:NREG-1];
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic              poly_act_r;
   logic              poly_act_nxt;
   logic              bsync_act_r;
   logic              bsync_act_nxt;

   // read-only bits keep their reset pattern, so a careless write cannot
   // disturb the reserved polyphase nibble or the sync lsb
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_reg
         always_comb begin
            regs_nxt[gi] = regs_r[gi];
            if (reg_wr && reg_addr == REG_OFS[gi]) begin
               regs_nxt[gi] = (reg_wdata & REG_WMASK[gi])
                            | (REG_RST[gi] & ~REG_WMASK[gi]);
            end
         end

         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               regs_r[gi] <= REG_RST[gi];
            end else if (ce) begin
               regs_r[gi] <= regs_nxt[gi];
            end
         end
      end
   endgenerate

   // unmapped addresses read as zero; data stand only in the cycle after a read
   always_comb begin
      rdata_nxt = '0;
      if (!reg_rd) begin
         rdata_nxt = '0;
      end else if (reg_addr == FILT_OFS) begin
         rdata_nxt = regs_r[FILT_IDX];
      end else if (reg_addr == POLY_OFS) begin
         rdata_nxt = regs_r[POLY_IDX];
      end else if (reg_addr == SYNC_OFS) begin
         rdata_nxt = regs_r[SYNC_IDX];
      end
   end

   // qualified enables trail the mode inputs by one cycle, like the other derived outputs
   always_comb begin
      poly_act_nxt  = ook_rx_mode && regs_r[SYNC_IDX][POLY_ON_BIT];
      bsync_act_nxt = continuous_rx_mode && !regs_r[SYNC_IDX][BSYNC_BIT];
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r     <= '0;
         poly_act_r  <= 1'b0;
         bsync_act_r <= 1'b0;
      end else if (ce) begin
         rdata_r     <= rdata_nxt;
         poly_act_r  <= poly_act_nxt;
         bsync_act_r <= bsync_act_nxt;
      end
   end

   assign reg_rdata                = rdata_r;
   assign passive_lpf_code         = regs_r[FILT_IDX][PASS_HI:PASS_LO];
   assign butterworth_cutoff_code  = regs_r[FILT_IDX][BUTT_HI:BUTT_LO];
   assign polyphase_centre_code    = regs_r[POLY_IDX][POLY_HI:POLY_LO];
   assign polyphase_filter_on      = regs_r[SYNC_IDX][POLY_ON_BIT];
   assign bit_sync_disable         = regs_r[SYNC_IDX][BSYNC_BIT];
   assign sync_word_recognition_on = regs_r[SYNC_IDX][SREC_BIT];
   assign sync_word_length         = regs_r[SYNC_IDX][SLEN_HI:SLEN_LO];
   assign sync_error_tolerance     = regs_r[SYNC_IDX][STOL_HI:STOL_LO];
   assign polyphase_filter_active  = poly_act_r;
   assign bit_sync_active          = bsync_act_r;

   // translated values are registered in the helper, one cycle behind their codes
   rfsc_code_if codes_if ();
   assign codes_if.pass_code = passive_lpf_code;
   assign codes_if.butt_code = butterworth_cutoff_code;
   assign codes_if.poly_code = polyphase_centre_code;
   assign codes_if.slen_code = sync_word_length;

   rfsc_code_calc #(
      .XTAL_KHZ (XTAL_KHZ)
   ) u_calc (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .ce           (ce),
      .codes        (codes_if),
      .pass_khz     (passive_lpf_khz),
      .butt_ofs_khz (butterworth_offset_khz),
      .poly_khz     (polyphase_centre_khz),
      .sync_bits    (sync_word_bits)
   );

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   // strobes only count while the clock enable is high
   sequence filt_wr_s;
      ce && reg_wr && reg_addr == FILT_OFS;
   endsequence
   sequence poly_wr_s;
      ce && reg_wr && reg_addr == POLY_OFS;
   endsequence
   sequence sync_wr_s;
      ce && reg_wr && reg_addr == SYNC_OFS;
   endsequence
   sequence read_s(logic [ADDR_W-1:0] ofs);
      ce && reg_rd && reg_addr == ofs;
   endsequence

   // write path: every writable field takes the written bits at the strobe edge
   pass_write_a: assert property (filt_wr_s |=>
      passive_lpf_code == $past(reg_wdata[PASS_HI:PASS_LO]))
      else $error("passive code did not take the written value");
   butt_write_a: assert property (filt_wr_s |=>
      butterworth_cutoff_code == $past(reg_wdata[BUTT_HI:BUTT_LO]))
      else $error("butterworth code did not take the written value");
   poly_write_a: assert property (poly_wr_s |=>
      polyphase_centre_code == $past(reg_wdata[POLY_HI:POLY_LO]))
      else $error("polyphase code did not take the written value");
   poly_rsv_a: assert property (read_s(POLY_OFS) |=>
      reg_rdata[PRSV_HI:PRSV_LO] == PRSV_VAL)
      else $error("reserved polyphase nibble lost its pattern");
   poly_read_a: assert property (read_s(POLY_OFS) |=>
      reg_rdata[POLY_HI:POLY_LO] == $past(polyphase_centre_code))
      else $error("polyphase code did not read back");
   filt_read_a: assert property (read_s(FILT_OFS) |=>
      reg_rdata == {$past(passive_lpf_code), $past(butterworth_cutoff_code)})
      else $error("filter register did not read back its fields");
   // the disable must reach the qualified output even if software never reads back
   bsync_off_a: assert property (sync_wr_s ##0 reg_wdata[BSYNC_BIT] ##1 ce && !reg_wr |=>
      !bit_sync_active)
      else $error("bit synchronizer still active after disable");
   // the flops are still held at the release edge, so that edge is left out
   bsync_on_a: assert property (ce && rstn && continuous_rx_mode && !bit_sync_disable |=>
      bit_sync_active)
      else $error("bit synchronizer not active in continuous receive");
   bsync_write_a: assert property (sync_wr_s |=>
      bit_sync_disable == $past(reg_wdata[BSYNC_BIT]))
      else $error("synchronizer disable bit did not take the written value");
   slen_write_a: assert property (sync_wr_s |=>
      sync_word_length == $past(reg_wdata[SLEN_HI:SLEN_LO]))
      else $error("sync length code did not take the written value");
   stol_write_a: assert property (sync_wr_s |=>
      sync_error_tolerance == $past(reg_wdata[STOL_HI:STOL_LO]))
      else $error("tolerance code did not take the written value");
   stol_read_a: assert property (sync_wr_s ##1 read_s(SYNC_OFS) |=>
      reg_rdata[STOL_HI:STOL_LO] == $past(reg_wdata[STOL_HI:STOL_LO], 2))
      else $error("tolerance code did not read back as written");
   sync_flags_a: assert property (sync_wr_s |=>
      polyphase_filter_on == $past(reg_wdata[POLY_ON_BIT])
      && sync_word_recognition_on == $past(reg_wdata[SREC_BIT]))
      else $error("sync enable bits did not take the written values");
   poly_act_a: assert property (ce |=>
      polyphase_filter_active == $past(ook_rx_mode && polyphase_filter_on))
      else $error("polyphase filter activity does not follow its enable");
   sync_lsb_a: assert property (read_s(SYNC_OFS) |=> !reg_rdata[SRSV_BIT])
      else $error("sync register lsb read as one");
   unmapped_a: assert property (ce && reg_rd && reg_addr != FILT_OFS && reg_addr != POLY_OFS
                                && reg_addr != SYNC_OFS |=> reg_rdata == '0)
      else $error("unmapped read returned nonzero data");
   // a stray write to an unused offset must leave the bank alone
   unmapped_wr_a: assert property (ce && reg_wr && reg_addr != FILT_OFS && reg_addr != POLY_OFS
                                   && reg_addr != SYNC_OFS |=> $stable(regs_r[FILT_IDX])
                                   && $stable(regs_r[POLY_IDX]) && $stable(regs_r[SYNC_IDX]))
      else $error("unmapped write changed a register");
   rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == '0)
      else $error("read data stood outside the cycle after a read");
   // a low enable freezes everything, read data and qualified outputs included
   freeze_a: assert property (!ce |=> $stable(regs_r[FILT_IDX]) && $stable(regs_r[POLY_IDX])
      && $stable(regs_r[SYNC_IDX]) && $stable(reg_rdata) && $stable(bit_sync_active))
      else $error("state moved while the clock enable was low");
endmodule

// *** rfsc_cfg_bank_tb_top.sv ***
// self-checking bench for the receiver filter and sync configuration bank
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module rfsc_cfg_bank_tb_top import rfsc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   // passive filter bandwidths in kHz, codes 0000 to 1111
   localparam logic [PASS_KHZ_W-1:0] PASS_EXP [0:15] = '{
      10'h041, 10'h052, 10'h06D, 10'h089, 10'h09D, 10'h0B8, 10'h0D3, 10'h0EA,
      10'h106, 10'h141, 10'h17A, 10'h19E, 10'h1CA, 10'h202, 10'h2A4, 10'h3DB};

   logic                  core_clk;
   logic                  rstn;
   logic                  ce;
   logic [ADDR_W-1:0]     reg_addr;
   logic [DATA_W-1:0]     reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic                  continuous_rx_mode;
   logic                  ook_rx_mode;
   logic [DATA_W-1:0]     reg_rdata;
   logic [CODE_W-1:0]     passive_lpf_code;
   logic [CODE_W-1:0]     butterworth_cutoff_code;
   logic [CODE_W-1:0]     polyphase_centre_code;
   logic                  polyphase_filter_on;
   logic                  bit_sync_disable;
   logic                  sync_word_recognition_on;
   logic [SLEN_W-1:0]     sync_word_length;
   logic [SLEN_W-1:0]     sync_error_tolerance;
   logic                  polyphase_filter_active;
   logic                  bit_sync_active;
   logic [PASS_KHZ_W-1:0] passive_lpf_khz;
   logic [FREQ_W-1:0]     butterworth_offset_khz;
   logic [FREQ_W-1:0]     polyphase_centre_khz;
   logic [SBITS_W-1:0]    sync_word_bits;
   int                    bad_count;
   int                    comparisons;

   rfsc_cfg_bank #(.XTAL_KHZ(XTAL_REF_KHZ)) DUT (
      .core_clk(core_clk), .rstn(rstn), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .continuous_rx_mode(continuous_rx_mode), .ook_rx_mode(ook_rx_mode),
      .passive_lpf_code(passive_lpf_code), .butterworth_cutoff_code(butterworth_cutoff_code),
      .polyphase_centre_code(polyphase_centre_code), .polyphase_filter_on(polyphase_filter_on),
      .bit_sync_disable(bit_sync_disable), .sync_word_recognition_on(sync_word_recognition_on),
      .sync_word_length(sync_word_length), .sync_error_tolerance(sync_error_tolerance),
      .polyphase_filter_active(polyphase_filter_active), .bit_sync_active(bit_sync_active),
      .passive_lpf_khz(passive_lpf_khz), .butterworth_offset_khz(butterworth_offset_khz),
      .polyphase_centre_khz(polyphase_centre_khz), .sync_word_bits(sync_word_bits));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // the cycle, bus and reset tasks start on a rising edge and return at a falling edge, outputs settled
   task automatic cyc;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      `CHK(reg_rdata, e)
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(negedge core_clk);
   endtask

   task automatic check_reset;
      `CHK(passive_lpf_code, 4'hA)
      `CHK(passive_lpf_khz, 10'h17A)
      `CHK(butterworth_cutoff_code, 4'h3)
      `CHK(butterworth_offset_khz, 12'h064)
      `CHK(polyphase_centre_code, 4'h3)
      `CHK(polyphase_centre_khz, 12'h064)
      `CHK(bit_sync_disable, 1'b0)
      `CHK(sync_word_length, 2'h3)
      `CHK(sync_word_bits, 6'h20)
      `CHK(sync_error_tolerance, 2'h0)
      `CHK(reg_rdata, 8'h00)
      rd(FILT_OFS, 8'hA3);
      rd(POLY_OFS, 8'h38);
      rd(SYNC_OFS, 8'h18);
   endtask

   task automatic filt_sweep;
      for (int i = 0; i < 16; i++) begin
         wr(FILT_OFS, {4'(i), 4'(15 - i)});
         `CHK(passive_lpf_code, 4'(i))
         `CHK(butterworth_cutoff_code, 4'(15 - i))
         cyc;
         `CHK(passive_lpf_khz, PASS_EXP[i])
         `CHK(butterworth_offset_khz, 12'(25 * (16 - i)))
      end
      rd(FILT_OFS, 8'hF0);
   endtask

   // software keeps the reserved low nibble at 1000, and it must read back so
   task automatic poly_sweep;
      for (int i = 0; i < 16; i++) begin
         wr(POLY_OFS, {4'(i), 4'h8});
         `CHK(polyphase_centre_code, 4'(i))
         cyc;
         `CHK(polyphase_centre_khz, 12'(25 * (i + 1)))
         rd(POLY_OFS, {4'(i), 4'h8});
      end
   endtask

   // bit zero is always written zero, as software must
   task automatic sync_sweep;
      logic [DATA_W-1:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 8'(8'h40 | (i << 3) | (i << 1) | ((i & 1) << 7) | ((i & 2) << 4));
         wr(SYNC_OFS, v);
         `CHK(sync_word_length, 2'(i))
         `CHK(sync_error_tolerance, 2'(i))
         `CHK(bit_sync_disable, 1'b1)
         `CHK(polyphase_filter_on, 1'(i & 1))
         `CHK(sync_word_recognition_on, 1'(i >> 1))
         cyc;
         `CHK(sync_word_bits, 6'(8 * (i + 1)))
         rd(SYNC_OFS, v);
      end
   endtask

   // starts with sync at 0xFE from the last sweep step: synchronizer off, polyphase on
   task automatic mode_qual;
      @(posedge core_clk);
      continuous_rx_mode <= 1'b1;
      ook_rx_mode <= 1'b1;
      cyc;
      `CHK(bit_sync_active, 1'b0)
      `CHK(polyphase_filter_active, 1'b1)
      wr(SYNC_OFS, 8'h18);
      cyc;
      `CHK(bit_sync_active, 1'b1)
      `CHK(polyphase_filter_active, 1'b0)
      @(posedge core_clk);
      continuous_rx_mode <= 1'b0;
      cyc;
      `CHK(bit_sync_active, 1'b0)
   endtask

   // a write and a read of the same offset with no gap between the strobes
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic bus_edges;
      wr_rd(FILT_OFS, 8'h5C);
      `CHK(reg_rdata, 8'h5C)
      `CHK(passive_lpf_khz, 10'h0B8)
      `CHK(butterworth_offset_khz, 12'h145)
      cyc;
      `CHK(reg_rdata, 8'h00)
      wr_rd(SYNC_OFS, 8'h14);
      `CHK(reg_rdata, 8'h14)
      `CHK(sync_error_tolerance, 2'h2)
      // a strobe to the sync offset while the enable is low; only the filter code is checked after it
      @(posedge core_clk);
      ce <= 1'b0;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      ce <= 1'b1;
      reg_wr <= 1'b0;
      @(negedge core_clk);
      `CHK(passive_lpf_code, 4'h5)
      wr(8'h13, 8'hFF);
      rd(8'h13, 8'h00);
      rd(FILT_OFS, 8'h5C);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      continuous_rx_mode = 1'b0;
      ook_rx_mode = 1'b0;
      bad_count = 0;
      comparisons = 0;
      do_reset;
      check_reset;
      filt_sweep;
      poly_sweep;
      sync_sweep;
      mode_qual;
      bus_edges;
      do_reset;
      check_reset;
      summarize;
   end
endmodule
